/* File: pkg/dap_pkg.sv */
// constants and carrier types for the dual-channel pipelined converter block
package dap_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // data path widths and depths
    localparam int DAP_CHANNELS  = 2;
    localparam int DAP_STAGES    = 9;
    localparam int DAP_PIPE_REGS = 5;
    localparam int DAP_WORD_W    = 10;
    localparam int DAP_IN_W      = 12;
    localparam int DAP_RES_W     = 14;
    localparam int DAP_CODE_W    = 12;
    localparam int DAP_EXT_W     = DAP_RES_W - DAP_IN_W;

    // residue scale: full scale of the held input is plus or minus the reference
    localparam logic signed [DAP_RES_W-1:0]  DAP_REF      = 14'sh0800;
    localparam logic signed [DAP_RES_W-1:0]  DAP_THRESH   = 14'sh0200;
    localparam logic signed [DAP_RES_W-1:0]  DAP_THRESH_N = -14'sh0200;
    localparam logic signed [DAP_CODE_W-1:0] DAP_CODE_ZERO = 12'sh000;
    localparam logic signed [DAP_CODE_W-1:0] DAP_CODE_ONE  = 12'sh001;
    localparam logic signed [DAP_CODE_W-1:0] DAP_CODE_MAX  = 12'sh1FF;
    localparam logic signed [DAP_CODE_W-1:0] DAP_CODE_MIN  = 12'shE00;
    localparam logic [DAP_WORD_W-1:0]        DAP_MSB_FLIP  = 10'h200;

    ////////////////////////////////////////////////////////////////////////////////
    // register bus
    localparam int DAP_ADDR_W = 8;
    localparam int DAP_DATA_W = 32;
    localparam int DAP_STRB_W = 4;
    localparam logic [DAP_ADDR_W-1:0] DAP_OFF_CONTROL = 8'h00;
    localparam logic [DAP_ADDR_W-1:0] DAP_OFF_STATUS  = 8'h04;
    localparam logic [DAP_ADDR_W-1:0] DAP_OFF_WORD_A  = 8'h08;
    localparam logic [DAP_ADDR_W-1:0] DAP_OFF_WORD_B  = 8'h0C;
    localparam logic [DAP_ADDR_W-1:0] DAP_OFF_COUNT   = 8'h10;
    localparam logic [1:0] DAP_RESP_OKAY   = 2'h0;
    localparam logic [1:0] DAP_RESP_SLVERR = 2'h2;

    // control field layout, bit 3 downward
    localparam int DAP_CTL_W = 4;
    localparam logic [DAP_CTL_W-1:0] DAP_CTL_RESET = 4'h8;
    localparam int DAP_STAT_W = 3;

    typedef struct packed {
        logic output_off;   // bit 3: drivers released
        logic power_down;   // bit 2: outputs latched, no new words
        logic sleep;        // bit 1: no new words; pipeline keeps sampling
        logic twos;         // bit 0: two's complement coding
    } dap_ctrl_type;

    typedef struct packed {
        logic signed [DAP_RES_W-1:0]  residue;
        logic signed [DAP_CODE_W-1:0] code;
    } dap_stage_type;

endpackage

/* File: logic/dap_stage.sv */
// one 1.5-bit pipeline stage: two comparators, residue amplifier, digit accumulation
`timescale 1ns/1ps
`default_nettype none

module dap_stage
    import dap_pkg::*;
(
    input  wire dap_stage_type stage_in,   // held residue and code so far
    output wire dap_stage_type stage_out   // amplified residue and extended code
);

    wire logic signed [DAP_RES_W-1:0]  doubled;
    wire logic signed [DAP_CODE_W-1:0] code_x2;
    wire logic                         digit_hi;
    wire logic                         digit_lo;

    // thresholds at a quarter reference leave a quarter reference of slack per side
    assign digit_hi = stage_in.residue > DAP_THRESH;
    assign digit_lo = stage_in.residue < DAP_THRESH_N;
    assign doubled  = stage_in.residue <<< 1;
    assign code_x2  = stage_in.code <<< 1;

    assign stage_out.residue = digit_hi ? doubled - DAP_REF :
                               digit_lo ? doubled + DAP_REF : doubled;
    // redundant digits overlap by one weight; adding them here absorbs comparator offset
    assign stage_out.code    = digit_hi ? code_x2 + DAP_CODE_ONE :
                               digit_lo ? code_x2 - DAP_CODE_ONE : code_x2;

endmodule // dap_stage

`default_nettype wire

/* File: logic/dap_top.sv */
// dual 10-bit pipelined converter digital side with AXI4-Lite control
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module dap_top
    import dap_pkg::*;
(
    input  wire logic                  aclk,                // converter and bus clock
    input  wire logic                  aresetn,             // synchronous reset, active low
    input  wire logic [DAP_ADDR_W-1:0] s_axi_awaddr,        // write address
    input  wire logic [2:0]            s_axi_awprot,        // write protection, unused
    input  wire logic                  s_axi_awvalid,       // write address valid
    output var  logic                  s_axi_awready,       // write address ready
    input  wire logic [DAP_DATA_W-1:0] s_axi_wdata,         // write data
    input  wire logic [DAP_STRB_W-1:0] s_axi_wstrb,         // write byte strobes
    input  wire logic                  s_axi_wvalid,        // write data valid
    output var  logic                  s_axi_wready,        // write data ready
    output var  logic [1:0]            s_axi_bresp,         // write response
    output var  logic                  s_axi_bvalid,        // write response valid
    input  wire logic                  s_axi_bready,        // write response ready
    input  wire logic [DAP_ADDR_W-1:0] s_axi_araddr,        // read address
    input  wire logic [2:0]            s_axi_arprot,        // read protection, unused
    input  wire logic                  s_axi_arvalid,       // read address valid
    output var  logic                  s_axi_arready,       // read address ready
    output var  logic [DAP_DATA_W-1:0] s_axi_rdata,         // read data
    output var  logic [1:0]            s_axi_rresp,         // read response
    output var  logic                  s_axi_rvalid,        // read data valid
    input  wire logic                  s_axi_rready,        // read data ready
    input  wire logic [DAP_IN_W-1:0]   analog_a,            // held channel A input, signed
    input  wire logic [DAP_IN_W-1:0]   analog_b,            // held channel B input, signed
    output wire logic [DAP_WORD_W-1:0] channel_a_word,      // channel A data port
    output var  logic                  channel_a_word_oe,   // channel A port drive enable
    output wire logic [DAP_WORD_W-1:0] channel_b_word,      // channel B data port
    output var  logic                  channel_b_word_oe    // channel B port drive enable
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    dap_ctrl_type              ctrl;
    logic [DAP_ADDR_W-1:0]     wr_addr;
    logic [DAP_DATA_W-1:0]     wr_data;
    logic [DAP_STRB_W-1:0]     wr_strb;
    logic [DAP_PIPE_REGS-1:0]  pipe_valid;
    logic                      word_seen;
    logic [DAP_DATA_W-1:0]     word_count;
    dap_stage_type             pipe      [DAP_CHANNELS][DAP_PIPE_REGS];
    dap_stage_type             stage_in  [DAP_CHANNELS][DAP_STAGES];
    dap_stage_type             stage_out [DAP_CHANNELS][DAP_STAGES];
    logic [DAP_WORD_W-1:0]     out_word  [DAP_CHANNELS];
    logic [DAP_WORD_W-1:0]     next_word [DAP_CHANNELS];
    logic [DAP_IN_W-1:0]       analog_in [DAP_CHANNELS];

    ////////////////////////////////////////////////////////////////////////////////
    // decode and selection

    wire logic                  run;
    wire logic                  word_update;
    wire logic                  wr_go;
    wire logic                  wr_control;
    wire logic                  wr_count;
    wire logic                  wr_readonly;
    wire logic                  rd_take;
    wire logic                  rd_mapped;
    wire logic [DAP_DATA_W-1:0] rd_value;
    wire logic [DAP_DATA_W-1:0] status_word;
    wire logic [DAP_DATA_W-1:0] ctrl_word;

    assign run         = !ctrl.sleep && !ctrl.power_down;
    // only a word whose sample went in while running may reach the ports
    assign word_update = pipe_valid[DAP_PIPE_REGS-1] && run;
    assign wr_go       = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_control  = wr_addr == DAP_OFF_CONTROL;
    assign wr_count    = wr_addr == DAP_OFF_COUNT;
    assign wr_readonly = (wr_addr == DAP_OFF_STATUS) || (wr_addr == DAP_OFF_WORD_A)
                         || (wr_addr == DAP_OFF_WORD_B);
    assign rd_take     = s_axi_arvalid && s_axi_arready;

    assign ctrl_word   = {{(DAP_DATA_W-DAP_CTL_W){1'b0}}, ctrl};
    assign status_word = {{(DAP_DATA_W-DAP_STAT_W){1'b0}}, |pipe_valid, word_seen, run};

    assign rd_mapped = (s_axi_araddr == DAP_OFF_CONTROL) || (s_axi_araddr == DAP_OFF_STATUS)
                       || (s_axi_araddr == DAP_OFF_WORD_A) || (s_axi_araddr == DAP_OFF_WORD_B)
                       || (s_axi_araddr == DAP_OFF_COUNT);
    assign rd_value  = (s_axi_araddr == DAP_OFF_CONTROL) ? ctrl_word :
                       (s_axi_araddr == DAP_OFF_STATUS)  ? status_word :
                       (s_axi_araddr == DAP_OFF_WORD_A)  ?
                           {{(DAP_DATA_W-DAP_WORD_W){1'b0}}, out_word[0]} :
                       (s_axi_araddr == DAP_OFF_WORD_B)  ?
                           {{(DAP_DATA_W-DAP_WORD_W){1'b0}}, out_word[1]} :
                       (s_axi_araddr == DAP_OFF_COUNT)   ? word_count : '0;

    assign analog_in[0] = analog_a;
    assign analog_in[1] = analog_b;

    // clamp the corrected sum to ten bits, then pick the coding
    function automatic logic [DAP_WORD_W-1:0] format_word(
        input logic signed [DAP_CODE_W-1:0] code,
        input logic                         twos
    );
        logic signed [DAP_CODE_W-1:0] clamped;
        clamped = (code > DAP_CODE_MAX) ? DAP_CODE_MAX :
                  (code < DAP_CODE_MIN) ? DAP_CODE_MIN : code;
        format_word = twos ? clamped[DAP_WORD_W-1:0]
                           : clamped[DAP_WORD_W-1:0] ^ DAP_MSB_FLIP;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order, response after both

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= DAP_RESP_OKAY;
            wr_addr       <= '0;
            wr_data       <= '0;
            wr_strb       <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                wr_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_control || wr_count || wr_readonly) ? DAP_RESP_OKAY
                                                                         : DAP_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // control register; only byte lane 0 carries fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= dap_ctrl_type'(DAP_CTL_RESET);
        end else if (wr_go && wr_control && wr_strb[0]) begin
            ctrl <= dap_ctrl_type'(wr_data[DAP_CTL_W-1:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read channel: one cycle from address taken to data

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= DAP_RESP_OKAY;
        end else if (rd_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_value;
            s_axi_rresp   <= rd_mapped ? DAP_RESP_OKAY : DAP_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sample tracking shared by both channels

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pipe_valid <= '0;
        end else begin
            // one flag per register keeps both channels tied to one sampling edge
            pipe_valid <= {pipe_valid[DAP_PIPE_REGS-2:0], run};
        end
    end

    // a write to the counter clears it; a word landing the same cycle still counts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            word_count <= '0;
            word_seen  <= 1'b0;
        end else begin
            if (word_update) begin
                word_count <= (wr_go && wr_count) ? DAP_DATA_W'(1) : word_count + 1'b1;
                word_seen  <= 1'b1;
            end else if (wr_go && wr_count) begin
                word_count <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // per-channel pipeline: two half-cycle stages between registers, the last stage alone before the output word, nine in all

    for (genvar ch = 0; ch < DAP_CHANNELS; ch++) begin : g_chan
        for (genvar s = 0; s < DAP_STAGES; s++) begin : g_stage
            if (s % 2 == 0) begin : g_from_reg
                assign stage_in[ch][s] = pipe[ch][s/2];
            end else begin : g_chain
                assign stage_in[ch][s] = stage_out[ch][s-1];
            end
            dap_stage u_stage (
                .stage_in  (stage_in[ch][s]),
                .stage_out (stage_out[ch][s])
            );
        end

        assign next_word[ch] = format_word(stage_out[ch][DAP_STAGES-1].code, ctrl.twos);

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                for (int k = 0; k < DAP_PIPE_REGS; k++) begin
                    pipe[ch][k] <= '0;
                end
                out_word[ch] <= '0;
            end else begin
                // input captured every edge; sleep only blocks the result
                pipe[ch][0] <= {{{DAP_EXT_W{analog_in[ch][DAP_IN_W-1]}}, analog_in[ch]},
                                DAP_CODE_ZERO};
                for (int k = 1; k < DAP_PIPE_REGS; k++) begin
                    pipe[ch][k] <= stage_out[ch][2*k-1];
                end
                if (word_update) begin
                    out_word[ch] <= next_word[ch];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // output ports

    assign channel_a_word = out_word[0];
    assign channel_b_word = out_word[1];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            channel_a_word_oe <= 1'b0;
            channel_b_word_oe <= 1'b0;
        end else begin
            channel_a_word_oe <= !ctrl.output_off;
            channel_b_word_oe <= !ctrl.output_off;
        end
    end

endmodule // dap_top

`default_nettype wire

/* File: sim/dap_top_asserts.sv */
// port-level checker for the dual converter block
`timescale 1ns/1ps
`default_nettype none
module dap_top_asserts
    import dap_pkg::*;
(
    input wire logic                  aclk,              // clock
    input wire logic                  aresetn,           // reset
    input wire logic [DAP_ADDR_W-1:0] s_axi_awaddr,      // aw
    input wire logic                  s_axi_awvalid,     // aw
    input wire logic                  s_axi_awready,     // aw
    input wire logic [DAP_DATA_W-1:0] s_axi_wdata,       // w
    input wire logic [DAP_STRB_W-1:0] s_axi_wstrb,       // w
    input wire logic                  s_axi_wvalid,      // w
    input wire logic                  s_axi_wready,      // w
    input wire logic [1:0]            s_axi_bresp,       // b
    input wire logic                  s_axi_bvalid,      // b
    input wire logic                  s_axi_bready,      // b
    input wire logic                  s_axi_arvalid,     // ar
    input wire logic                  s_axi_arready,     // ar
    input wire logic                  s_axi_rvalid,      // r
    input wire logic                  s_axi_rready,      // r
    input wire logic [DAP_WORD_W-1:0] channel_a_word,    // port a
    input wire logic                  channel_a_word_oe, // enable a
    input wire logic [DAP_WORD_W-1:0] channel_b_word,    // port b
    input wire logic                  channel_b_word_oe  // enable b
);
    ////////////////////////////////////////////////////////////////////////////////
    // shadow of the control word, rebuilt from bus traffic; lags the design by one edge
    logic [7:0] aw_q;
    logic [4:0] wd_q;
    logic [3:0] sh;
    logic       bv_q;
    wire logic  aw_ok = aw_q inside {DAP_OFF_CONTROL, DAP_OFF_STATUS, DAP_OFF_WORD_A,
                                     DAP_OFF_WORD_B, DAP_OFF_COUNT};
    always_ff @(posedge aclk) begin
        bv_q <= aresetn && s_axi_bvalid;
        if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) wd_q <= {s_axi_wstrb[0], s_axi_wdata[3:0]};
        if (!aresetn) sh <= DAP_CTL_RESET;
        else if (s_axi_bvalid && !bv_q && aw_q == DAP_OFF_CONTROL && wd_q[4]) sh <= wd_q[3:0];
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_oe_follow: assert property (channel_a_word_oe == !sh[3])
        else $error("port enable does not follow the disable bit");
    a_oe_pair: assert property (channel_a_word_oe == channel_b_word_oe)
        else $error("port enables differ");
    a_hold_stop: assert property (sh[2:1] != 2'h0 |=>
        $stable(channel_a_word) && $stable(channel_b_word))
        else $error("port word changed while halted");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read response dropped");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid) else $error("late write answer");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("late read answer");
    a_wr_resp: assert property (s_axi_bvalid |->
        s_axi_bresp == (aw_ok ? DAP_RESP_OKAY : DAP_RESP_SLVERR)) else $error("bad bresp");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_halt: cover property (sh[2:1] != 2'h0 && channel_a_word_oe);
endmodule // dap_top_asserts
`default_nettype wire

/* File: sim/dap_capture.sv */
// capture logic on the far side of the converter ports
`timescale 1ns/1ps
`default_nettype none
module dap_capture (
    input  wire logic       aclk,   // converter clock
    input  wire logic [9:0] word_a, // port a
    input  wire logic       oe_a,   // enable a
    input  wire logic [9:0] word_b, // port b
    input  wire logic       oe_b,   // enable b
    output var  logic [9:0] cap_a,  // word taken
    output var  logic [9:0] cap_b,  // word taken
    output var  logic       cap_on  // port was driven
);
    // no pull on the lines: an undriven port shows the inverse of the last word
    wire logic [9:0] line_a = oe_a ? word_a : ~cap_a;
    wire logic [9:0] line_b = oe_b ? word_b : ~cap_b;
    initial {cap_a, cap_b, cap_on} = 21'h000000;
    always @(posedge aclk) begin
        cap_a  <= line_a;
        cap_b  <= line_b;
        cap_on <= oe_a && oe_b;
    end
endmodule // dap_capture
`default_nettype wire

/* File: sim/test_dual_adc_parallel_output.sv */
// self-checking bench for the dual converter block
`timescale 1ns/1ps
`default_nettype none
module test_dual_adc_parallel_output
    import dap_pkg::*;
;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, channel_a_word_oe, channel_b_word_oe, cap_on, twos;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [11:0] analog_a, analog_b, ha[0:7], hb[0:7];
    logic [9:0]  channel_a_word, channel_b_word, cap_a, cap_b, held_a, held_b;
    logic [15:0] lfsr;
    int          fail_count, comparisons;
    dap_top dut (.*);
    dap_capture u_cap (.aclk(aclk), .word_a(channel_a_word), .oe_a(channel_a_word_oe),
        .word_b(channel_b_word), .oe_b(channel_b_word_oe), .cap_a(cap_a), .cap_b(cap_b),
        .cap_on(cap_on));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [9:0] exp_word(input logic [11:0] x, input logic t);
        logic signed [13:0] c;
        c = ($signed({{2{x[11]}}, x}) + 14'sh0002) >>> 2;
        if (c > 14'sh01FF) c = 14'sh01FF;
        return c[9:0] ^ (t ? 10'h000 : DAP_MSB_FLIP);
    endfunction
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one code of slack: the ideal rounding of the stage chain is not pinned down
    task automatic cmp_near(input logic [9:0] got, input logic [9:0] exp);
        comparisons++;
        if ((^got === 1'bx) || ((got - exp) > 10'h001 && (exp - got) > 10'h001)) begin
            fail_count++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            ad = ad | s_axi_awready;
            wd = wd | s_axi_wready;
            if (ad) s_axi_awvalid <= 1'b0;
            if (wd) s_axi_wvalid <= 1'b0;
        end while (!(ad && wd));
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        s_axi_bready <= 1'b0;
        cmp_val(32'(s_axi_bresp), 32'(er));
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        s_axi_rready <= 1'b0;
        cmp_val(s_axi_rdata, ed);
        cmp_val(32'(s_axi_rresp), 32'(er));
    endtask
    // fixed words for the first three samples, then random words on both channels, each port word checked against its own sample;
    // while halted the ports must keep the words latched before the halt
    task automatic stream(input int n, input logic halted);
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            lfsr = lfsr_next(lfsr);
            for (int k = 7; k > 0; k--) {ha[k], hb[k]} = {ha[k-1], hb[k-1]};
            ha[0] = (i < 3) ? 12'h7FF ^ (12'hFFF * i[0]) : lfsr[11:0];
            hb[0] = (i < 3) ? 12'h800 * i[1] : lfsr[15:4];
            {analog_a, analog_b} <= {ha[0], hb[0]};
            #1;
            if (halted) begin
                cmp_val(32'({channel_a_word, channel_b_word}), 32'({held_a, held_b}));
            end else if (i >= 7) begin
                cmp_near(channel_a_word, exp_word(ha[6], twos));
                cmp_near(channel_b_word, exp_word(hb[6], twos));
                cmp_near(cap_a, exp_word(ha[7], twos));
                cmp_near(cap_b, exp_word(hb[7], twos));
            end
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    initial begin
        repeat (6000) @(posedge aclk);
        fail_count++;
        $display("mismatch at %0t: run did not finish", $time);
        wrap_up();
    end
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 22'h000000;
        {s_axi_wdata, s_axi_wstrb, analog_a, analog_b} = 60'h0;
        {aresetn, twos, lfsr, fail_count, comparisons} = {2'h0, 16'hC585, 64'h0};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(DAP_OFF_CONTROL, 32'h00000008, DAP_RESP_OKAY);
        cmp_val(32'(channel_a_word_oe), 32'h00000000);
        axi_rd(8'h20, 32'h00000000, DAP_RESP_SLVERR);
        axi_wr(8'h20, 32'h00000000, 4'hF, DAP_RESP_SLVERR);
        axi_wr(DAP_OFF_CONTROL, 32'h00000000, 4'h0, DAP_RESP_OKAY);
        axi_rd(DAP_OFF_CONTROL, 32'h00000008, DAP_RESP_OKAY);
        axi_wr(DAP_OFF_CONTROL, 32'h00000000, 4'h1, DAP_RESP_OKAY);
        repeat (8) @(posedge aclk);
        #1;
        cmp_val(32'({channel_a_word_oe, channel_b_word_oe, cap_on}), 32'h00000007);
        cmp_val(32'({channel_a_word, channel_b_word}), 32'h00080200);
        axi_wr(DAP_OFF_WORD_A, 32'h00000000, 4'hF, DAP_RESP_OKAY);
        axi_rd(DAP_OFF_WORD_A, 32'h00000200, DAP_RESP_OKAY);
        stream(60, 1'b0);
        for (int m = 1; m < 3; m++) begin
            axi_wr(DAP_OFF_CONTROL, 32'h00000001 << m, 4'h1, DAP_RESP_OKAY);
            {held_a, held_b} = {channel_a_word, channel_b_word};
            stream(10, 1'b1);
            cmp_val(32'({channel_a_word, channel_b_word}), 32'({held_a, held_b}));
            axi_rd(DAP_OFF_STATUS, 32'h00000002, DAP_RESP_OKAY);
            axi_wr(DAP_OFF_CONTROL, 32'h00000000, 4'h1, DAP_RESP_OKAY);
            stream(14, 1'b0);
        end
        axi_wr(DAP_OFF_CONTROL, 32'h00000001, 4'h1, DAP_RESP_OKAY);
        twos = 1'b1;
        stream(60, 1'b0);
        axi_wr(DAP_OFF_CONTROL, 32'h00000008, 4'h1, DAP_RESP_OKAY);
        repeat (3) @(posedge aclk);
        #1;
        cmp_val(32'({channel_a_word_oe, channel_b_word_oe, cap_on}), 32'h00000000);
        wrap_up();
    end
endmodule // test_dual_adc_parallel_output
bind dap_top dap_top_asserts u_chk (.*);
`default_nettype wire
